// file: rtl/hc_buf_pkg.sv
// constants, codes and types shared by both ends of the buffer status link
package hc_buf_pkg;

  // command codes on the shared bus; bit 7 marks a write
  localparam logic [7:0] CMD_BUFFER_STATUS_RD = 8'h2c;
  localparam logic [7:0] CMD_ISO_A_LEN_RD     = 8'h2d;
  localparam logic [7:0] CMD_ISO_B_LEN_RD     = 8'h2e;
  localparam logic [7:0] CMD_XFER_COUNT_RD    = 8'h22;
  localparam logic [7:0] CMD_XFER_COUNT_WR    = 8'ha2;
  localparam logic [7:0] CMD_ISO_PORT_RD      = 8'h40;
  localparam logic [7:0] CMD_ISO_PORT_WR      = 8'hc0;
  localparam logic [7:0] CMD_ASYNC_PORT_RD    = 8'h41;
  localparam logic [7:0] CMD_ASYNC_PORT_WR    = 8'hc1;
  localparam logic [7:0] CMD_WRITE_MASK       = 8'h80;

  // buffer status field positions
  localparam int ISO_A_FULL_BIT     = 0;
  localparam int ISO_B_FULL_BIT     = 1;
  localparam int ASYNC_FULL_BIT     = 2;
  localparam int ISO_A_DONE_BIT     = 3;
  localparam int ISO_B_DONE_BIT     = 4;
  localparam int ASYNC_DONE_BIT     = 5;
  localparam int FULL_FIELD_LSB     = 0;
  localparam int DONE_FIELD_LSB     = 3;

  // reset values
  localparam logic [15:0] BUFFER_STATUS_RESET = 16'h0000;
  localparam logic [15:0] READBACK_LEN_RESET  = 16'h0000;
  localparam logic [15:0] XFER_COUNT_RESET    = 16'h0000;
  localparam logic [15:0] PTR_RESET           = 16'h0000;

  // each port data word moves the byte pointer by this much
  localparam logic [15:0] PTR_STEP = 16'h0002;

  // buffer ram: 4 kbyte as 16-bit words, one fixed window per list
  localparam int          RAM_WORDS  = 2048;
  localparam int          ADDR_W     = 11;
  localparam logic [10:0] ISO_A_BASE = 11'h000;
  localparam logic [10:0] ISO_B_BASE = 11'h200;
  localparam logic [10:0] ASYNC_BASE = 11'h400;

  localparam int LIST_COUNT = 3;

  typedef enum logic [1:0]
  {
    LIST_ISO_A = 2'b00,
    LIST_ISO_B = 2'b01,
    LIST_ASYNC = 2'b10
  } list_sel_t;

  typedef enum logic [1:0]
  {
    HOST_IDLE = 2'b00,
    HOST_CMD  = 2'b01,
    HOST_DATA = 2'b10,
    HOST_WAIT = 2'b11
  } host_state_t;

endpackage

// file: rtl/hc_buf_if.sv
// command/data link between the processor end and the controller end
`timescale 1ns/1ps
interface hc_buf_if;
  logic        cmd_valid;
  logic [7:0]  cmd_code;
  logic        rd_strobe;
  logic        wr_strobe;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        rdata_valid;

  modport device
  (
    input  cmd_valid,
    input  cmd_code,
    input  rd_strobe,
    input  wr_strobe,
    input  wdata,
    output rdata,
    output rdata_valid
  );

  modport host
  (
    output cmd_valid,
    output cmd_code,
    output rd_strobe,
    output wr_strobe,
    output wdata,
    input  rdata,
    input  rdata_valid
  );
endinterface

// file: rtl/hc_sticky_flag.sv
// one status flag with separate set and clear events, set has priority
`timescale 1ns/1ps
module hc_sticky_flag
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic set_evt,
  input  wire logic clr_evt,
  output logic      flag
);

  // a set landing with a clear keeps the flag, so no event is lost
  always_ff @(posedge core_clk)
  begin
    if (rst)
      flag <= 1'b0;
    else if (set_evt)
      flag <= 1'b1;
    else if (clr_evt)
      flag <= 1'b0;
  end

endmodule

// file: rtl/hc_buf_device.sv
// controller end: buffer status, read-back lengths, ports and buffer ram
`timescale 1ns/1ps
module hc_buf_device
  import hc_buf_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  hc_buf_if.device         bus,
  input  wire logic [2:0]  hc_list_read,
  input  wire logic        iso_a_rx_valid,
  input  wire logic [15:0] iso_a_rx_bytes,
  input  wire logic        iso_b_rx_valid,
  input  wire logic [15:0] iso_b_rx_bytes,
  output logic             end_of_transfer_irq,
  output logic [15:0]      status_view
);

  logic [7:0]        cmd_reg;
  logic [15:0]       transfer_byte_counter;
  logic [15:0]       buf_ptr;
  list_sel_t         active_list;
  logic [15:0]       iso_a_readback_bytes;
  logic [15:0]       iso_b_readback_bytes;
  logic [15:0]       buffer_status;
  logic [2:0]        full_flags;
  logic [2:0]        done_flags;
  logic [2:0]        full_set;
  logic [2:0]        full_clr;
  logic [2:0]        done_set;
  logic [2:0]        done_clr;
  logic [15:0]       ram [RAM_WORDS];
  logic              is_port_cmd;
  logic              port_is_write;
  logic              port_access;
  logic              eot;
  logic [15:0]       next_ptr;
  logic [ADDR_W-1:0] list_base;
  logic [ADDR_W-1:0] word_addr;
  logic [15:0]       read_mux;

  // the port commands are the only ones that touch the ram
  assign is_port_cmd = (cmd_reg == CMD_ISO_PORT_RD)   || (cmd_reg == CMD_ISO_PORT_WR) ||
                       (cmd_reg == CMD_ASYNC_PORT_RD) || (cmd_reg == CMD_ASYNC_PORT_WR);
  assign port_is_write = cmd_reg[7];

  // accesses past the counter are ignored so the pointer cannot run off
  assign port_access = is_port_cmd && (buf_ptr < transfer_byte_counter) &&
                       (port_is_write ? bus.wr_strobe : bus.rd_strobe);

  // pointer steps by a whole word per access
  assign next_ptr = buf_ptr + PTR_STEP;

  // end of transfer once the pointer meets the byte count
  assign eot = port_access && (next_ptr >= transfer_byte_counter);

  // window base for the list currently in play
  always_comb
  begin
    unique case (active_list)
      LIST_ISO_A: list_base = ISO_A_BASE;
      LIST_ISO_B: list_base = ISO_B_BASE;
      LIST_ASYNC: list_base = ASYNC_BASE;
      default:    list_base = ISO_A_BASE;
    endcase
  end

  // byte pointer to word address; odd counts still take a whole word
  assign word_addr = list_base + buf_ptr[ADDR_W:1];

  // command phase: latch code, restart pointer, choose the list
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cmd_reg     <= 8'h00;
      active_list <= LIST_ISO_A;
    end
    else if (bus.cmd_valid)
    begin
      cmd_reg <= bus.cmd_code;
      unique case (bus.cmd_code)
        // writes fill list A first, then B while A waits for the controller
        CMD_ISO_PORT_WR:   active_list <= full_flags[LIST_ISO_A] ? LIST_ISO_B : LIST_ISO_A;
        // read-back takes list A once the controller has finished with it, otherwise list B
        CMD_ISO_PORT_RD:   active_list <= done_flags[LIST_ISO_A] ? LIST_ISO_A : LIST_ISO_B;
        CMD_ASYNC_PORT_RD: active_list <= LIST_ASYNC;
        CMD_ASYNC_PORT_WR: active_list <= LIST_ASYNC;
        default:           active_list <= active_list;
      endcase
    end
  end

  // byte pointer, restarted by every new command
  always_ff @(posedge core_clk)
  begin
    if (rst)
      buf_ptr <= PTR_RESET;
    else if (bus.cmd_valid)
      buf_ptr <= PTR_RESET;
    else if (port_access)
      buf_ptr <= next_ptr;
  end

  // transfer byte counter, written by the processor
  always_ff @(posedge core_clk)
  begin
    if (rst)
      transfer_byte_counter <= XFER_COUNT_RESET;
    else if (bus.wr_strobe && (cmd_reg == CMD_XFER_COUNT_WR))
      transfer_byte_counter <= bus.wdata;
  end

  // buffer ram write side
  always_ff @(posedge core_clk)
  begin
    if (port_access && port_is_write)
      ram[word_addr] <= bus.wdata;
  end

  // read-back lengths come from the controller after an iso frame
  always_ff @(posedge core_clk)
  begin
    if (rst)
      iso_a_readback_bytes <= READBACK_LEN_RESET;
    else if (iso_a_rx_valid)
      iso_a_readback_bytes <= iso_a_rx_bytes;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      iso_b_readback_bytes <= READBACK_LEN_RESET;
    else if (iso_b_rx_valid)
      iso_b_readback_bytes <= iso_b_rx_bytes;
  end

  // flag events: a written-out buffer is full and not yet read;
  // a processor read-back empties it; the controller reading it marks done
  always_comb
  begin
    for (int i = 0; i < LIST_COUNT; i++)
    begin
      full_set[i] = eot && port_is_write && (active_list == list_sel_t'(i));
      full_clr[i] = (eot && !port_is_write && (active_list == list_sel_t'(i))) ||
                    hc_list_read[i];
      done_set[i] = hc_list_read[i];
      done_clr[i] = eot && (active_list == list_sel_t'(i));
    end
  end

  // one full flag and one done flag per list
  for (genvar g = 0; g < LIST_COUNT; g++)
  begin : g_list
    hc_sticky_flag u_full
    (
      .core_clk (core_clk),
      .rst      (rst),
      .set_evt  (full_set[g]),
      .clr_evt  (full_clr[g]),
      .flag     (full_flags[g])
    );
    hc_sticky_flag u_done
    (
      .core_clk (core_clk),
      .rst      (rst),
      .set_evt  (done_set[g]),
      .clr_evt  (done_clr[g]),
      .flag     (done_flags[g])
    );
  end

  // status word; upper bits reserved and read as zero
  always_comb
  begin
    buffer_status                 = BUFFER_STATUS_RESET;
    buffer_status[ISO_A_FULL_BIT] = full_flags[LIST_ISO_A];
    buffer_status[ISO_B_FULL_BIT] = full_flags[LIST_ISO_B];
    buffer_status[ASYNC_FULL_BIT] = full_flags[LIST_ASYNC];
    buffer_status[ISO_A_DONE_BIT] = done_flags[LIST_ISO_A];
    buffer_status[ISO_B_DONE_BIT] = done_flags[LIST_ISO_B];
    buffer_status[ASYNC_DONE_BIT] = done_flags[LIST_ASYNC];
  end

  // read data selection; unknown and write-only codes read zero
  always_comb
  begin
    unique case (cmd_reg)
      CMD_BUFFER_STATUS_RD: read_mux = buffer_status;
      CMD_ISO_A_LEN_RD:     read_mux = iso_a_readback_bytes;
      CMD_ISO_B_LEN_RD:     read_mux = iso_b_readback_bytes;
      CMD_XFER_COUNT_RD:    read_mux = transfer_byte_counter;
      CMD_ISO_PORT_RD:      read_mux = ram[word_addr];
      CMD_ASYNC_PORT_RD:    read_mux = ram[word_addr];
      default:              read_mux = 16'h0000;
    endcase
  end

  // registered read answer one cycle after the strobe; status reads
  // only sample, they never feed any set or clear term
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      bus.rdata       <= 16'h0000;
      bus.rdata_valid <= 1'b0;
    end
    else
    begin
      bus.rdata_valid <= bus.rd_strobe;
      if (bus.rd_strobe)
        bus.rdata <= read_mux;
    end
  end

  // end-of-transfer event for interrupt bit 2 of the processor interrupt word
  always_ff @(posedge core_clk)
  begin
    if (rst)
      end_of_transfer_irq <= 1'b0;
    else
      end_of_transfer_irq <= eot;
  end

  // status copy for the controller engine
  always_ff @(posedge core_clk)
  begin
    if (rst)
      status_view <= BUFFER_STATUS_RESET;
    else
      status_view <= buffer_status;
  end

endmodule

// file: rtl/hc_buf_host.sv
// processor end: turns user requests into command and data phases
`timescale 1ns/1ps
module hc_buf_host
  import hc_buf_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  hc_buf_if.host           bus,
  input  wire logic        req_valid,
  input  wire logic        req_new_cmd,
  input  wire logic [7:0]  req_code,
  input  wire logic        req_write,
  input  wire logic [15:0] req_wdata,
  output logic             req_ready,
  output logic             req_error,
  output logic             resp_valid,
  output logic [15:0]      resp_data
);

  host_state_t state;
  logic        write_q;
  logic        ro_write;

  // the status and length registers have no write code
  assign ro_write = req_new_cmd && (req_code[7] || req_write) &&
    (((req_code & ~CMD_WRITE_MASK) == CMD_BUFFER_STATUS_RD) ||
     ((req_code & ~CMD_WRITE_MASK) == CMD_ISO_A_LEN_RD) ||
     ((req_code & ~CMD_WRITE_MASK) == CMD_ISO_B_LEN_RD));

  assign req_ready     = (state == HOST_IDLE);
  assign bus.cmd_valid = (state == HOST_CMD);
  assign bus.rd_strobe = (state == HOST_DATA) && !write_q;
  assign bus.wr_strobe = (state == HOST_DATA) && write_q;

  // sequencer: command once, then one data word per request
  always_ff @(posedge core_clk)
  begin
    if (rst)
      state <= HOST_IDLE;
    else
    begin
      unique case (state)
        HOST_IDLE:
          if (req_valid && !ro_write)
            state <= req_new_cmd ? HOST_CMD : HOST_DATA;
        HOST_CMD:  state <= HOST_DATA;
        HOST_DATA: state <= write_q ? HOST_IDLE : HOST_WAIT;
        HOST_WAIT:
          if (bus.rdata_valid)
            state <= HOST_IDLE;
      endcase
    end
  end

  // request fields held for the bus phases
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      bus.cmd_code <= 8'h00;
      bus.wdata    <= 16'h0000;
      write_q      <= 1'b0;
    end
    else if ((state == HOST_IDLE) && req_valid && !ro_write)
    begin
      if (req_new_cmd)
        bus.cmd_code <= req_code;
      bus.wdata <= req_wdata;
      write_q   <= req_write;
    end
  end

  // refused write to a read-only register, one-cycle pulse
  always_ff @(posedge core_clk)
  begin
    if (rst)
      req_error <= 1'b0;
    else
      req_error <= (state == HOST_IDLE) && req_valid && ro_write;
  end

  // answer to a read, held until the next one
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      resp_valid <= 1'b0;
      resp_data  <= 16'h0000;
    end
    else
    begin
      resp_valid <= (state == HOST_WAIT) && bus.rdata_valid;
      if ((state == HOST_WAIT) && bus.rdata_valid)
        resp_data <= bus.rdata;
    end
  end

endmodule

// file: tb/hc_buf_link_asserts.sv
// concurrent checks on the command link between the two ends
`timescale 1ns/1ps
module hc_buf_link_asserts
  import hc_buf_pkg::*;
(
  input logic        core_clk,
  input logic        rst,
  input logic        cmd_valid,
  input logic [7:0]  cmd_code,
  input logic        rd_strobe,
  input logic        wr_strobe,
  input logic [15:0] wdata,
  input logic [15:0] rdata,
  input logic        rdata_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // a status command followed at once by its data read
  sequence status_rd_s;
    cmd_valid && cmd_code == CMD_BUFFER_STATUS_RD ##1 rd_strobe;
  endsequence

  rd_answer_a: assert property (rd_strobe |=> rdata_valid)
    else $error("read strobe not answered next cycle");
  answer_cause_a: assert property (rdata_valid |-> $past(rd_strobe))
    else $error("read answer without a read strobe");
  answer_pulse_a: assert property (rdata_valid |=> !rdata_valid)
    else $error("read answer longer than one cycle");
  rdata_hold_a: assert property (!rdata_valid |-> $stable(rdata))
    else $error("read word moved without a read");
  status_reserved_a: assert property (status_rd_s |=> rdata[15:6] == 10'h000)
    else $error("reserved status bits not zero");
  no_ro_write_a: assert property (cmd_valid && cmd_code[7] |->
    !(cmd_code[6:0] inside {7'h2c, 7'h2d, 7'h2e}))
    else $error("write command sent to a read-only register");
  strobe_excl_a: assert property (!(rd_strobe && wr_strobe) && !(cmd_valid && rd_strobe))
    else $error("phases overlap on the link");
  cmd_data_a: assert property (cmd_valid |=> rd_strobe || wr_strobe)
    else $error("command phase not followed by a data phase");
endmodule

// file: tb/hc_buffer_status_readback_tb_top.sv
// self-checking bench joining the processor end to the controller end
`timescale 1ns/1ps
module hc_buffer_status_readback_tb_top import hc_buf_pkg::*;;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  hc_list_read = 3'h0;
  logic        iso_a_rx_valid = 1'b0;
  logic [15:0] iso_a_rx_bytes = 16'h0000;
  logic        iso_b_rx_valid = 1'b0;
  logic [15:0] iso_b_rx_bytes = 16'h0000;
  logic        req_valid = 1'b0;
  logic        req_new_cmd = 1'b0;
  logic [7:0]  req_code = 8'h00;
  logic        req_write = 1'b0;
  logic [15:0] req_wdata = 16'h0000;
  logic        end_of_transfer_irq, req_ready, req_error, resp_valid, err, got;
  logic [15:0] status_view, resp_data, rd, exp;
  int          fails = 0;
  int          check_count = 0;
  int          eot_seen = 0;

  always #5 core_clk = ~core_clk;

  hc_buf_if link ();
  hc_buf_device hc_buf_device_i
  (
    .core_clk            (core_clk),
    .rst                 (rst),
    .bus                 (link),
    .hc_list_read        (hc_list_read),
    .iso_a_rx_valid      (iso_a_rx_valid),
    .iso_a_rx_bytes      (iso_a_rx_bytes),
    .iso_b_rx_valid      (iso_b_rx_valid),
    .iso_b_rx_bytes      (iso_b_rx_bytes),
    .end_of_transfer_irq (end_of_transfer_irq),
    .status_view         (status_view)
  );
  hc_buf_host hc_buf_host_i
  (
    .core_clk    (core_clk),
    .rst         (rst),
    .bus         (link),
    .req_valid   (req_valid),
    .req_new_cmd (req_new_cmd),
    .req_code    (req_code),
    .req_write   (req_write),
    .req_wdata   (req_wdata),
    .req_ready   (req_ready),
    .req_error   (req_error),
    .resp_valid  (resp_valid),
    .resp_data   (resp_data)
  );
  hc_buf_link_asserts hc_buf_link_asserts_i
  (
    .core_clk    (core_clk),
    .rst         (rst),
    .cmd_valid   (link.cmd_valid),
    .cmd_code    (link.cmd_code),
    .rd_strobe   (link.rd_strobe),
    .wr_strobe   (link.wr_strobe),
    .wdata       (link.wdata),
    .rdata       (link.rdata),
    .rdata_valid (link.rdata_valid)
  );

  // count end-of-transfer pulses away from the launching edge
  always @(negedge core_clk)
    if (end_of_transfer_irq === 1'b1)
      eot_seen++;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one user request held over the taking edge; answer watched for six cycles
  task automatic req(input logic nc, input logic [7:0] code, input logic wr,
                     input logic [15:0] wd);
    int n;
    n = 0;
    got = 1'b0;
    err = 1'b0;
    @(posedge core_clk);
    req_valid   <= 1'b1;
    req_new_cmd <= nc;
    req_code    <= code;
    req_write   <= wr;
    req_wdata   <= wd;
    do
    begin
      @(negedge core_clk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 20);
    @(posedge core_clk);
    req_valid <= 1'b0;
    for (int k = 0; k < 6; k++)
    begin
      @(negedge core_clk);
      if (resp_valid === 1'b1)
      begin
        rd = resp_data;
        got = 1'b1;
      end
      if (req_error === 1'b1)
        err = 1'b1;
    end
    // a hang or a lost answer ends the run
    if (n >= 20 || (!wr && !got))
    begin
      fails++;
      $display("ERROR request %h expected answer seen none", code);
      stop_test();
    end
  endtask

  task automatic pulse_list(input logic [2:0] which);
    @(posedge core_clk);
    hc_list_read <= which;
    @(posedge core_clk);
    hc_list_read <= 3'h0;
  endtask

  initial
  begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      req(1'b1, CMD_BUFFER_STATUS_RD + 8'(i), 1'b0, 16'h0000);
      check("reset value", rd, 16'h0000);
    end
    $display("test reset done");
    // writes aimed at the read-only codes must be turned away
    for (int i = 0; i < 3; i++)
    begin
      req(1'b1, CMD_BUFFER_STATUS_RD + 8'(i) | CMD_WRITE_MASK, 1'b1, 16'hffff);
      check("refused write", {15'h0000, err}, 16'h0001);
    end
    $display("test refuse done");
    @(posedge core_clk);
    iso_a_rx_valid <= 1'b1;
    iso_a_rx_bytes <= 16'h0004;
    iso_b_rx_valid <= 1'b1;
    iso_b_rx_bytes <= 16'hfffd;
    @(posedge core_clk);
    iso_a_rx_valid <= 1'b0;
    iso_b_rx_valid <= 1'b0;
    // each length read twice: reading must not disturb it
    for (int k = 0; k < 4; k++)
    begin
      req(1'b1, CMD_ISO_A_LEN_RD + 8'(k % 2), 1'b0, 16'h0000);
      check("readback length", rd, (k % 2) ? 16'hfffd : 16'h0004);
    end
    $display("test length done");
    // first fill lands in list A, the second in list B because A is full
    req(1'b1, CMD_XFER_COUNT_WR, 1'b1, 16'h0004);
    for (int b = 0; b < 2; b++)
    begin
      // words differ per list so a read-back from the wrong window shows
      req(1'b1, CMD_ISO_PORT_WR, 1'b1, 16'h1234 + 16'(b));
      req(1'b0, CMD_ISO_PORT_WR, 1'b1, 16'h5678 + 16'(b));
      req(1'b1, CMD_BUFFER_STATUS_RD, 1'b0, 16'h0000);
      check("iso fill status", rd, b ? 16'h0003 : 16'h0001);
    end
    req(1'b1, CMD_XFER_COUNT_WR, 1'b1, 16'h0002);
    req(1'b1, CMD_ASYNC_PORT_WR, 1'b1, 16'h9abc);
    req(1'b0, CMD_ASYNC_PORT_WR, 1'b1, 16'h9abc);
    req(1'b1, CMD_BUFFER_STATUS_RD, 1'b0, 16'h0000);
    check("async fill status", rd, 16'h0007);
    $display("test fill done");
    // controller reads the lists one by one: done rises, full falls
    for (int i = 0; i < 3; i++)
    begin
      pulse_list(3'h1 << i);
      exp = (16'h0007 & ~((16'h0002 << i) - 16'h0001)) | (((16'h0002 << i) - 16'h0001) << 3);
      req(1'b1, CMD_BUFFER_STATUS_RD, 1'b0, 16'h0000);
      check("done status", rd, exp);
      check("status view", status_view, exp);
    end
    $display("test done flags done");
    req(1'b1, CMD_ISO_A_LEN_RD, 1'b0, 16'h0000);
    req(1'b1, CMD_XFER_COUNT_WR, 1'b1, rd);
    req(1'b1, CMD_ISO_PORT_RD, 1'b0, 16'h0000);
    check("iso word 0", rd, 16'h1234);
    req(1'b0, CMD_ISO_PORT_RD, 1'b0, 16'h0000);
    check("iso word 1", rd, 16'h5678);
    req(1'b1, CMD_BUFFER_STATUS_RD, 1'b0, 16'h0000);
    check("readback status", rd, 16'h0030);
    // odd byte count for list B: the second word covers the last byte
    @(posedge core_clk);
    iso_b_rx_valid <= 1'b1;
    iso_b_rx_bytes <= 16'h0003;
    @(posedge core_clk);
    iso_b_rx_valid <= 1'b0;
    req(1'b1, CMD_ISO_B_LEN_RD, 1'b0, 16'h0000);
    check("iso b length", rd, 16'h0003);
    req(1'b1, CMD_XFER_COUNT_WR, 1'b1, rd);
    req(1'b1, CMD_ISO_PORT_RD, 1'b0, 16'h0000);
    check("iso b word 0", rd, 16'h1235);
    req(1'b0, CMD_ISO_PORT_RD, 1'b0, 16'h0000);
    check("iso b word 1", rd, 16'h5679);
    req(1'b1, CMD_BUFFER_STATUS_RD, 1'b0, 16'h0000);
    check("iso b status", rd, 16'h0020);
    check("eot count", 16'(eot_seen), 16'h0005);
    $display("test readback done");
    stop_test();
  end
endmodule
